/* File: bench/rotate_and_sleep_exec_asserts.sv */
// Port assertions for the rotate/sleep executor.
// Assumes the opcode header is on the include path.
`timescale 1ns/1ps
`include "rotsleep_regs.vh"
module rse_chk (
    input wire        clk,
    input wire        rst,
    input wire [13:0] instr,
    input wire        instr_valid,
    input wire        wake_up,
    input wire        instr_ready,
    input wire        fetch_halt,
    input wire        osc_stop
);
    wire slp = instr_valid && instr == `SLEEP_WORD;
    wire rot = instr_valid && (instr[13:8] == `OP_ROT_RIGHT || instr[13:8] == `OP_ROT_LEFT);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // Sleep entry, stay and wake; rotate completion
    // ----------------------------------------
    AST_SLP_ACK: assert property (slp && !fetch_halt |-> instr_ready) else $error("sleep not taken");
    AST_SLP_HALT: assert property (slp && instr_ready |=> fetch_halt && osc_stop) else $error("no halt");
    AST_PAIR: assert property (fetch_halt == osc_stop) else $error("halt pair split");
    AST_HOLD: assert property (fetch_halt && !wake_up |=> fetch_halt) else $error("left sleep");
    AST_WAKE: assert property (fetch_halt && wake_up |=> !fetch_halt) else $error("no wake");
    AST_ASLEEP: assert property (fetch_halt |-> !instr_ready) else $error("took instr asleep");
    AST_ROT: assert property (rot && !fetch_halt && !instr_ready |=> instr_ready) else $error("rot late");
    AST_RUN: assert property (!fetch_halt && !(slp && instr_ready) |=> !fetch_halt) else $error("stray halt");
    cover property (slp && instr_ready);
    cover property (fetch_halt && wake_up);
    cover property (rot && instr_ready);
endmodule // rse_chk

bind rotate_and_sleep_exec rse_chk u_chk (.clk(clk), .rst(rst), .instr(instr), .instr_valid(instr_valid),
    .wake_up(wake_up), .instr_ready(instr_ready), .fetch_halt(fetch_halt), .osc_stop(osc_stop));

/* File: bench/tb_rotate_and_sleep_exec.sv */
// Self-checking bench for the rotate/sleep executor.
// Assumes a 20 ns clock and the register map of the design.
`timescale 1ns/1ps
`include "rotsleep_regs.vh"
module tb_rotate_and_sleep_exec;
    reg         clk = 0, rst = 1, instr_valid = 0, wake_up = 0, reg_wr = 0, reg_rd = 0, d, c, lt;
    reg  [13:0] instr = 0;
    reg  [15:0] reg_addr = 0, lf = 16'h002a;
    reg  [7:0]  reg_wdata = 0, w_m, v, q;
    reg  [8:0]  r;
    reg  [6:0]  f;
    wire        instr_ready, fetch_halt, osc_stop;
    wire [7:0]  reg_rdata;
    integer     failures = 0, check_count = 0, i, k;
    always #10 clk = ~clk;
    rotate_and_sleep_exec DUT (.clk(clk), .rst(rst), .instr(instr), .instr_valid(instr_valid),
        .wake_up(wake_up), .instr_ready(instr_ready), .fetch_halt(fetch_halt), .osc_stop(osc_stop),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function [15:0] nx(input [15:0] x);
        nx = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // Returns {carry out, result}
    function [8:0] rotx(input l, input ci, input [7:0] x);
        rotx = l ? {x[7], x[6:0], ci} : {x[0], ci, x[7:1]};
    endfunction
    task conclude;
        begin
            $display("checks %0d mismatches %0d", check_count, failures);
            if (failures == 0 && check_count > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task chk(input [47:0] nm, input [7:0] e, input [7:0] g);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("BAD %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task wr(input [15:0] a, input [7:0] dt);
        begin
            @(posedge clk);
            reg_wr <= 1;
            reg_addr <= a;
            reg_wdata <= dt;
            @(posedge clk);
            reg_wr <= 0;
        end
    endtask
    // File-window data stand only in the cycle after the strobe
    task rd(input [15:0] a, output [7:0] dt);
        begin
            @(posedge clk);
            reg_rd <= 1;
            reg_addr <= a;
            @(posedge clk);
            reg_rd <= 0;
            @(negedge clk);
            dt = reg_rdata;
        end
    endtask
    task ex(input [13:0] op);
        begin
            @(posedge clk);
            instr <= op;
            instr_valid <= 1;
            k = 0;
            @(negedge clk);
            while (instr_ready !== 1'b1 && k < 4) begin
                k = k + 1;
                @(negedge clk);
            end
            if (instr_ready !== 1'b1) begin
                failures = failures + 1;
                conclude;
            end
            @(posedge clk);
            instr_valid <= 0;
        end
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        rd(`SEL_STATUS, q); chk("status", 8'h18, q);
        rd(`SEL_FLAGS, q); chk("flags", 8'h06, q);
        rd(16'h0010, q); chk("unmap", 8'h00, q);
        $display("reset test done");
        w_m = 0;
        for (i = 0; i < 24; i = i + 1) begin
            lf = nx(lf);
            f = (i == 0) ? 7'h7f : (i == 1) ? 7'h00 : lf[6:0];
            lt = i[0];
            d = i[1];
            c = lf[7];
            v = (i < 2) ? {8{i[0]}} : lf[15:8];
            wr(`SEL_FILE_BASE + f, v);
            wr(`SEL_STATUS, {7'h0c, c});
            ex({5'b00110, lt, d, f});
            r = rotx(lt, c, v);
            if (!d) w_m = r[7:0];
            rd(`SEL_WREG, q); chk("wreg", w_m, q);
            rd(`SEL_FILE_BASE + f, q); chk("file", d ? r[7:0] : v, q);
            rd(`SEL_STATUS, q); chk("status", {7'h0c, r[8]}, q);
        end
        // An opcode outside this block is taken and leaves state alone
        ex(14'h0764);
        rd(`SEL_STATUS, q); chk("other", {7'h0c, r[8]}, q);
        rd(`SEL_WREG, q); chk("otherw", w_m, q);
        $display("rotate test done");
        repeat (600) @(posedge clk);
        ex(`SLEEP_WORD);
        @(negedge clk); chk("halt", 8'h03, {6'h00, fetch_halt, osc_stop});
        @(posedge clk);
        instr <= 14'h0c81;
        instr_valid <= 1;
        repeat (5) begin @(negedge clk); chk("asleep", 8'h03, {5'h00, instr_ready, fetch_halt, osc_stop}); end
        @(posedge clk);
        instr_valid <= 0;
        wake_up <= 1;
        @(posedge clk);
        wake_up <= 0;
        @(negedge clk); chk("woke", 8'h00, {6'h00, fetch_halt, osc_stop});
        rd(`SEL_STATUS, q); chk("status", {7'h08, r[8]}, q);
        rd(`SEL_WATCHDOG, q); chk("wdog", 8'h00, q);
        rd(`SEL_FLAGS, q); chk("flags", 8'h04, q);
        // Cleared prescaler: first watchdog step lands 256 clocks after sleep
        repeat (241) @(posedge clk);
        rd(`SEL_WATCHDOG, q); chk("wdog", 8'h00, q);
        rd(`SEL_WATCHDOG, q); chk("wdog", 8'h01, q);
        $display("sleep test done");
        conclude;
    end
endmodule // tb_rotate_and_sleep_exec

/* File: hw/file_ram.v */
// Data memory of 128 bytes with one write port and a registered read port.
// Assumes a single clock; read data appear one cycle after the address.
`timescale 1ns/1ps
module file_ram (
    clk,
    we,
    waddr,
    wdata,
    raddr,
    rdata
);
    input  wire       clk;
    input  wire       we;
    input  wire [6:0] waddr;
    input  wire [7:0] wdata;
    input  wire [6:0] raddr;
    output reg  [7:0] rdata;

    reg [7:0] mem [0:127];

    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // file_ram

/* File: hw/rotate_and_sleep_exec.v */
// Executes rotate-through-carry and power-down instructions of an 8-bit core.
// Assumes the fetch logic holds instr stable while instr_valid is high, and that
// wake_up comes from an always-running source while the core clock gate is off.
//
// Summary of operation
// - Right rotate: carry into top, bit0 out
// - Destination bit picks working or file register
// - Left rotate: carry into bit0, bit7 out
// - Sleep clears watchdog, prescaler, powerdown_flag_n; sets timeout_flag_n
`timescale 1ns/1ps
`include "rotsleep_regs.vh"
module rotate_and_sleep_exec (
    clk,
    rst,
    instr,
    instr_valid,
    wake_up,
    instr_ready,
    fetch_halt,
    osc_stop,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata
);
    input  wire        clk;
    input  wire        rst;
    input  wire [13:0] instr;
    input  wire        instr_valid;
    input  wire        wake_up;
    output wire        instr_ready;
    output reg         fetch_halt;
    output reg         osc_stop;
    input  wire [15:0] reg_addr;
    input  wire [7:0]  reg_wdata;
    input  wire        reg_wr;
    input  wire        reg_rd;
    output reg  [7:0]  reg_rdata;

    localparam ST_RUN   = 2'd0;
    localparam ST_FETCH = 2'd1;
    localparam ST_SLEEP = 2'd2;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    reg [1:0]             state_r;
    reg [1:0]             state_nxt;
    reg [7:0]             wreg_r;
    reg [7:0]             status_r;
    reg [`WATCHDOG_WIDTH-1:0] watchdog_counter_r;
    reg [`PRESC_WIDTH-1:0] presc_r;
    reg                   rd_file_r;
    reg [7:0]             rd_mux_r;

    // ------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------
    wire [5:0] op_hi            = instr[`OP_HI_MSB:`OP_HI_LSB];
    wire       dest             = instr[`DEST_BIT];
    wire [6:0] faddr            = instr[`FADDR_MSB:0];
    wire       is_rot_right     = (op_hi == `OP_ROT_RIGHT);
    wire       is_rot_left      = (op_hi == `OP_ROT_LEFT);
    wire       is_sleep         = (instr == `SLEEP_WORD);
    wire       carry            = status_r[`ST_CARRY];
    wire       timeout_flag_n   = status_r[`ST_TIMEOUT_N];
    wire       powerdown_flag_n = status_r[`ST_POWERDOWN_N];

    // Rotates need the operand read first, so they take a fetch beat
    // before the one-cycle execute; sleep executes at once.
    wire exec_rot   = (state_r == ST_FETCH);
    wire exec_sleep = (state_r == ST_RUN) && instr_valid && is_sleep;
    assign instr_ready = exec_rot || exec_sleep ||
                         ((state_r == ST_RUN) && instr_valid && !is_rot_right && !is_rot_left);

    // ------------------------------------------------------------
    // Data memory
    // ------------------------------------------------------------
    wire [7:0] file_q;
    reg        ram_we;
    reg  [6:0] ram_waddr;
    reg  [7:0] ram_wdata;
    // Full-width compare; the file window is 128 bytes aligned
    wire       bus_file = ((reg_addr & 16'hff80) == `SEL_FILE_BASE);
    wire [6:0] ram_raddr = (state_r == ST_RUN && instr_valid) ? faddr : reg_addr[6:0];

    file_ram u_ram (
        .clk   (clk),
        .we    (ram_we),
        .waddr (ram_waddr),
        .wdata (ram_wdata),
        .raddr (ram_raddr),
        .rdata (file_q)
    );

    // ------------------------------------------------------------
    // Rotate datapath
    // ------------------------------------------------------------
    reg [7:0] rot_res;
    reg       rot_c;
    always @* begin
        rot_res = file_q;
        rot_c   = carry;
        if (is_rot_right) begin
            rot_res = {carry, file_q[7:1]};
            rot_c   = file_q[0];
        end else if (is_rot_left) begin
            rot_res = {file_q[6:0], carry};
            rot_c   = file_q[7];
        end
    end

    always @* begin
        ram_we    = 1'b0;
        ram_waddr = reg_addr[6:0];
        ram_wdata = reg_wdata;
        if (exec_rot && dest) begin
            ram_we    = 1'b1;
            ram_waddr = faddr;
            ram_wdata = rot_res;
        end else if (reg_wr && bus_file) begin
            ram_we = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (exec_sleep)
                    state_nxt = ST_SLEEP;
                else if (instr_valid && (is_rot_right || is_rot_left))
                    state_nxt = ST_FETCH;
            end
            ST_FETCH: state_nxt = ST_RUN;
            ST_SLEEP: begin
                if (wake_up)
                    state_nxt = ST_RUN;
            end
            default:  state_nxt = ST_RUN;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            state_r    <= ST_RUN;
            fetch_halt <= 1'b0;
            osc_stop   <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            fetch_halt <= (state_nxt == ST_SLEEP);
            osc_stop   <= (state_nxt == ST_SLEEP);
        end
    end

    // ------------------------------------------------------------
    // Watchdog count
    // ------------------------------------------------------------
    // Free-running prescaler; no time-out action is built here,
    // the count is only seen through the register port.
    always @(posedge clk) begin
        if (rst) begin
            watchdog_counter_r <= `WATCHDOG_RST;
            presc_r            <= `PRESC_RST;
        end else if (exec_sleep) begin
            watchdog_counter_r <= `WATCHDOG_RST;
            presc_r            <= `PRESC_RST;
        end else begin
            presc_r <= presc_r + 8'h01;
            if (presc_r == 8'hff)
                watchdog_counter_r <= watchdog_counter_r + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Working and status registers
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            wreg_r   <= 8'h00;
            status_r <= `STATUS_RST;
        end else begin
            if (reg_wr && reg_addr == `SEL_WREG)
                wreg_r <= reg_wdata;
            if (reg_wr && reg_addr == `SEL_STATUS)
                status_r <= reg_wdata;
            // Instruction effects land after bus writes so they win
            if (exec_rot) begin
                status_r[`ST_CARRY] <= rot_c;
                if (!dest)
                    wreg_r <= rot_res;
            end
            if (exec_sleep) begin
                status_r[`ST_TIMEOUT_N]   <= 1'b1;
                status_r[`ST_POWERDOWN_N] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            rd_file_r <= 1'b0;
            rd_mux_r  <= 8'h00;
        end else begin
            rd_file_r <= reg_rd && bus_file;
            case (reg_addr)
                `SEL_WREG:     rd_mux_r <= wreg_r;
                `SEL_STATUS:   rd_mux_r <= status_r;
                `SEL_WATCHDOG: rd_mux_r <= watchdog_counter_r;
                `SEL_FLAGS:    rd_mux_r <= {5'h00, timeout_flag_n, powerdown_flag_n, fetch_halt};
                default:       rd_mux_r <= 8'h00;
            endcase
        end
    end

    always @* begin
        reg_rdata = rd_file_r ? file_q : rd_mux_r;
    end
endmodule // rotate_and_sleep_exec

/* File: pkg/rotsleep_regs.vh */
// Opcode fields, status bit positions and reset values for the rotate/sleep executor.
// Assumes a 14-bit instruction word and an 8-bit data path.
`ifndef ROTSLEEP_REGS_VH
`define ROTSLEEP_REGS_VH

`define OP_HI_MSB        13
`define OP_HI_LSB        8
`define OP_ROT_RIGHT     6'h0c
`define OP_ROT_LEFT      6'h0d
`define DEST_BIT         7
`define FADDR_MSB        6
`define SLEEP_WORD       14'h0063

`define ST_CARRY         0
`define ST_POWERDOWN_N   3
`define ST_TIMEOUT_N     4
`define STATUS_RST       8'h18

`define WATCHDOG_WIDTH   8
`define PRESC_WIDTH      8
`define WATCHDOG_RST     8'h00
`define PRESC_RST        8'h00

`define SEL_REG_SPACE    16'h0000
`define SEL_WREG         16'h0001
`define SEL_STATUS       16'h0002
`define SEL_WATCHDOG     16'h0003
`define SEL_FLAGS        16'h0004
`define SEL_FILE_BASE    16'h0080

`endif
